// File: rtl/codec_status_tx_ctl.sv
// control and status registers, dac level path and transmitter data control
`timescale 1ns/100ps
`default_nettype none
module codec_status_tx_ctl (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire codec_ctl_pkg::reg_req_t reg_req,
    output logic [7:0] rdata,
    input wire logic left_right_clock,
    input wire logic dac_mute,
    input wire logic [7:0] vol_a,
    input wire logic [7:0] vol_b,
    input wire codec_ctl_pkg::sample_pair_t dac_in,
    input wire logic dac_in_valid,
    output codec_ctl_pkg::sample_pair_t dac_out,
    output logic dac_out_valid,
    output logic [9:0] atten_a,
    output logic [9:0] atten_b,
    input wire codec_ctl_pkg::sample_pair_t tx_in,
    input wire logic tx_in_valid,
    input wire logic cs_in_a,
    input wire logic cs_in_b,
    input wire logic tx_line_in,
    input wire logic copy_slot,
    input wire logic clock_fault_raw,
    input wire logic over_range_raw,
    input wire logic under_range_raw,
    output codec_ctl_pkg::sample_pair_t tx_sub,
    output logic tx_sub_valid,
    output logic tx_cs_a,
    output logic tx_cs_b,
    output logic tx_validity,
    output logic tx_pin,
    output logic [1:0] tx_format_sel,
    output logic cbuf_access_width,
    output logic copy_strobe
);
    typedef struct packed {
        logic [7:0] dac_ctl;
        logic [7:0] mask;
        logic [7:0] mode_hi;
        logic [7:0] mode_lo;
        logic [7:0] cbuf;
        logic [7:0] tx;
        logic [7:0] rdata;
        logic lr_s1;
        logic lr_s2;
        logic lr_prev;
        logic sign_a;
        logic sign_b;
        codec_ctl_pkg::sample_pair_t dac_out;
        logic dac_out_valid;
        codec_ctl_pkg::sample_pair_t tx_sub;
        logic tx_sub_valid;
        logic tx_cs_a;
        logic tx_cs_b;
        logic tx_pin;
        logic copy_strobe;
        logic copy_done;
    } top_state_t;
    top_state_t st_reg;
    top_state_t st_next;

    logic lr_tick;
    logic [1:0] zc;
    logic [1:0] change_mode;
    logic [7:0] tgt_a;
    logic [7:0] tgt_b;
    logic status_read;
    logic [7:0] cond_raw;
    logic [7:0] status_flags;
    logic [1:0] ch_sign;
    codec_ctl_pkg::sample_pair_t tx_pick;
    logic mono_cs;

    function automatic logic [23:0] flip_sample(input logic [23:0] x);
        logic [23:0] r;
        if (x == codec_ctl_pkg::SAMPLE_MIN) r = codec_ctl_pkg::SAMPLE_MAX;
        else r = ~x + 24'h000001;
        return r;
    endfunction : flip_sample

    assign lr_tick = st_reg.lr_s2 && !st_reg.lr_prev;
    assign change_mode = {st_reg.dac_ctl[codec_ctl_pkg::DAC_RAMP_BIT],
                          st_reg.dac_ctl[codec_ctl_pkg::DAC_WAIT_BIT]};
    assign tgt_a = dac_mute ? codec_ctl_pkg::MUTE_CODE : vol_a;
    assign tgt_b = dac_mute ? codec_ctl_pkg::MUTE_CODE : vol_b;
    assign ch_sign = {dac_in.a[codec_ctl_pkg::SIGN_BIT], dac_in.b[codec_ctl_pkg::SIGN_BIT]};
    assign zc[1] = dac_in_valid && (ch_sign[1] != st_reg.sign_a);
    assign zc[0] = dac_in_valid && (ch_sign[0] != st_reg.sign_b);
    assign status_read = reg_req.rd && reg_req.addr == codec_ctl_pkg::ADDR_EVENT_STATUS;

    always_comb begin
        cond_raw = 8'h00;
        cond_raw[codec_ctl_pkg::EV_COPY_BIT] = st_reg.copy_done;
        cond_raw[codec_ctl_pkg::EV_CLOCK_BIT] = clock_fault_raw;
        cond_raw[codec_ctl_pkg::EV_OVER_BIT] = over_range_raw;
        cond_raw[codec_ctl_pkg::EV_UNDER_BIT] = under_range_raw;
    end

    level_ramp u_ramp_a (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .lr_tick(lr_tick),
        .zero_cross(zc[1]),
        .mode(change_mode),
        .target_code(tgt_a),
        .level(atten_a)
    );

    level_ramp u_ramp_b (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .lr_tick(lr_tick),
        .zero_cross(zc[0]),
        .mode(change_mode),
        .target_code(tgt_b),
        .level(atten_b)
    );

    event_flags u_events (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .cond_raw(cond_raw),
        .mask(st_reg.mask),
        .mode_hi(st_reg.mode_hi),
        .mode_lo(st_reg.mode_lo),
        .read_clear(status_read),
        .flags(status_flags)
    );

    always_comb begin
        mono_cs = st_reg.tx[codec_ctl_pkg::TX_MONOSEL_BIT] ? cs_in_b : cs_in_a;
        tx_pick = tx_in;
        if (st_reg.tx[codec_ctl_pkg::TX_MONO_BIT]) begin
            tx_pick.a = st_reg.tx[codec_ctl_pkg::TX_MONOSEL_BIT] ? tx_in.b : tx_in.a;
            tx_pick.b = tx_pick.a;
        end
        if (st_reg.tx[codec_ctl_pkg::TX_MUTE_BIT]) begin
            tx_pick.a = codec_ctl_pkg::SAMPLE_ZERO;
            tx_pick.b = codec_ctl_pkg::SAMPLE_ZERO;
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.lr_s1 = left_right_clock;
        st_next.lr_s2 = st_reg.lr_s1;
        st_next.lr_prev = st_reg.lr_s2;
        if (reg_req.wr) begin
            case (reg_req.addr)
                codec_ctl_pkg::ADDR_DAC_CHANGE:
                    st_next.dac_ctl = reg_req.wdata & codec_ctl_pkg::DAC_WMASK;
                codec_ctl_pkg::ADDR_EVENT_MASK:
                    st_next.mask = reg_req.wdata & codec_ctl_pkg::EVENT_WMASK;
                codec_ctl_pkg::ADDR_MODE_HIGH:
                    st_next.mode_hi = reg_req.wdata & codec_ctl_pkg::EVENT_WMASK;
                codec_ctl_pkg::ADDR_MODE_LOW:
                    st_next.mode_lo = reg_req.wdata & codec_ctl_pkg::EVENT_WMASK;
                codec_ctl_pkg::ADDR_CBUF_XFER:
                    st_next.cbuf = reg_req.wdata & codec_ctl_pkg::CBUF_WMASK;
                codec_ctl_pkg::ADDR_TX_OUT:
                    st_next.tx = reg_req.wdata & codec_ctl_pkg::TX_WMASK;
                default: begin
                end
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                codec_ctl_pkg::ADDR_DAC_CHANGE: st_next.rdata = st_reg.dac_ctl;
                codec_ctl_pkg::ADDR_EVENT_STATUS: st_next.rdata = status_flags;
                codec_ctl_pkg::ADDR_EVENT_MASK: st_next.rdata = st_reg.mask;
                codec_ctl_pkg::ADDR_MODE_HIGH: st_next.rdata = st_reg.mode_hi;
                codec_ctl_pkg::ADDR_MODE_LOW: st_next.rdata = st_reg.mode_lo;
                codec_ctl_pkg::ADDR_CBUF_XFER: st_next.rdata = st_reg.cbuf;
                codec_ctl_pkg::ADDR_TX_OUT: st_next.rdata = st_reg.tx;
                default: st_next.rdata = codec_ctl_pkg::ZERO_RESET;
            endcase
        end
        st_next.dac_out_valid = dac_in_valid;
        if (dac_in_valid) begin
            st_next.sign_a = ch_sign[1];
            st_next.sign_b = ch_sign[0];
            if (st_reg.dac_ctl[codec_ctl_pkg::DAC_FLIP_BIT]) begin
                st_next.dac_out.a = flip_sample(dac_in.a);
                st_next.dac_out.b = flip_sample(dac_in.b);
            end else begin
                st_next.dac_out = dac_in;
            end
        end
        st_next.tx_sub_valid = tx_in_valid;
        if (tx_in_valid) st_next.tx_sub = tx_pick;
        if (st_reg.tx[codec_ctl_pkg::TX_CSSRC_BIT]) begin
            st_next.tx_cs_a = mono_cs;
            st_next.tx_cs_b = mono_cs;
        end else begin
            st_next.tx_cs_a = cs_in_a;
            st_next.tx_cs_b = cs_in_b;
        end
        st_next.tx_pin = st_reg.tx[codec_ctl_pkg::TX_OFF_BIT] ? 1'b0 : tx_line_in;
        st_next.copy_strobe = copy_slot && !st_reg.cbuf[codec_ctl_pkg::HOLD_BIT];
        st_next.copy_done = st_reg.copy_strobe;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
            st_reg.dac_ctl <= codec_ctl_pkg::DAC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign dac_out = st_reg.dac_out;
    assign dac_out_valid = st_reg.dac_out_valid;
    assign tx_sub = st_reg.tx_sub;
    assign tx_sub_valid = st_reg.tx_sub_valid;
    assign tx_cs_a = st_reg.tx_cs_a;
    assign tx_cs_b = st_reg.tx_cs_b;
    assign tx_validity = st_reg.tx[codec_ctl_pkg::TX_VALID_BIT];
    assign tx_pin = st_reg.tx_pin;
    assign tx_format_sel = {st_reg.tx[codec_ctl_pkg::TX_FMT_HI],
                            st_reg.tx[codec_ctl_pkg::TX_FMT_LO]};
    assign cbuf_access_width = st_reg.cbuf[codec_ctl_pkg::WIDTH_BIT];
    assign copy_strobe = st_reg.copy_strobe;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence copy_allowed;
        copy_slot && !st_reg.cbuf[codec_ctl_pkg::HOLD_BIT];
    endsequence
    sequence copy_then_done;
        copy_strobe ##1 st_reg.copy_done;
    endsequence

    a_copy_sequence: assert property (copy_allowed |=> copy_then_done)
        else $error("allowed copy did not strobe and complete");
    a_copy_hold: assert property (st_reg.cbuf[codec_ctl_pkg::HOLD_BIT] |=> !copy_strobe)
        else $error("copy strobed while held");
    a_polarity_out: assert property (dac_in_valid && st_reg.dac_ctl[codec_ctl_pkg::DAC_FLIP_BIT]
        && dac_in.a != codec_ctl_pkg::SAMPLE_MIN
        |=> dac_out.a + $past(dac_in.a) == codec_ctl_pkg::SAMPLE_ZERO)
        else $error("flipped sample is not the negation");
    a_driver_low: assert property (st_reg.tx[codec_ctl_pkg::TX_OFF_BIT] |=> !tx_pin ##1 !tx_pin
        or !st_reg.tx[codec_ctl_pkg::TX_OFF_BIT])
        else $error("transmit pin not held low");
    a_mute_zero: assert property (tx_in_valid && st_reg.tx[codec_ctl_pkg::TX_MUTE_BIT]
        |=> tx_sub_valid && tx_sub == '0)
        else $error("muted transmitter sent nonzero data");
    a_validity_copy: assert property (reg_req.wr && reg_req.addr == codec_ctl_pkg::ADDR_TX_OUT
        |=> tx_validity == $past(reg_req.wdata[codec_ctl_pkg::TX_VALID_BIT]))
        else $error("validity flag differs from written control bit");
    a_mono_data: assert property (tx_in_valid && st_reg.tx[codec_ctl_pkg::TX_MONO_BIT]
        && !st_reg.tx[codec_ctl_pkg::TX_MUTE_BIT]
        |=> tx_sub.a == tx_sub.b && tx_sub.a == ($past(st_reg.tx[codec_ctl_pkg::TX_MONOSEL_BIT])
        ? $past(tx_in.b) : $past(tx_in.a)))
        else $error("mono subframes carry wrong channel");
    a_cs_source: assert property (st_reg.tx[codec_ctl_pkg::TX_CSSRC_BIT]
        |=> tx_cs_a == tx_cs_b)
        else $error("status source bit did not unify subframes");
    a_masked_read: assert property (status_read |=> (rdata & ~$past(st_reg.mask)) == 8'h00)
        else $error("masked status bit read as one");
    a_reserved_zero: assert property (reg_req.wr && reg_req.addr == codec_ctl_pkg::ADDR_CBUF_XFER
        |=> (st_reg.cbuf & ~codec_ctl_pkg::CBUF_WMASK) == 8'h00)
        else $error("reserved bits stored a write");
endmodule : codec_status_tx_ctl
`default_nettype wire

// File: rtl/codec_ctl_pkg.sv
// constants and carrier types for the codec status and transmitter control block
`default_nettype none
package codec_ctl_pkg;
    localparam logic [7:0] ADDR_DAC_CHANGE = 8'h0C;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h0D;
    localparam logic [7:0] ADDR_EVENT_MASK = 8'h0E;
    localparam logic [7:0] ADDR_MODE_HIGH = 8'h0F;
    localparam logic [7:0] ADDR_MODE_LOW = 8'h10;
    localparam logic [7:0] ADDR_CBUF_XFER = 8'h11;
    localparam logic [7:0] ADDR_TX_OUT = 8'h12;
    localparam logic [7:0] DAC_WMASK = 8'hE0;
    localparam logic [7:0] EVENT_WMASK = 8'h1B;
    localparam logic [7:0] CBUF_WMASK = 8'h60;
    localparam logic [7:0] TX_WMASK = 8'hFF;
    localparam logic [7:0] DAC_RESET = 8'hC0;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    localparam int DAC_RAMP_BIT = 7;
    localparam int DAC_WAIT_BIT = 6;
    localparam int DAC_FLIP_BIT = 5;
    localparam int EV_COPY_BIT = 4;
    localparam int EV_CLOCK_BIT = 3;
    localparam int EV_OVER_BIT = 1;
    localparam int EV_UNDER_BIT = 0;
    localparam int HOLD_BIT = 6;
    localparam int WIDTH_BIT = 5;
    localparam int TX_FMT_HI = 7;
    localparam int TX_FMT_LO = 6;
    localparam int TX_OFF_BIT = 5;
    localparam int TX_MUTE_BIT = 4;
    localparam int TX_VALID_BIT = 3;
    localparam int TX_MONO_BIT = 2;
    localparam int TX_CSSRC_BIT = 1;
    localparam int TX_MONOSEL_BIT = 0;
    localparam logic [1:0] MODE_IMMEDIATE = 2'h0;
    localparam logic [1:0] MODE_WAIT = 2'h1;
    localparam logic [1:0] MODE_RAMP = 2'h2;
    localparam logic [1:0] EVM_RISE = 2'h0;
    localparam logic [1:0] EVM_FALL = 2'h1;
    localparam logic [1:0] EVM_LEVEL = 2'h2;
    localparam int LEVEL_W = 10;
    localparam int SAMPLE_W = 24;
    localparam int SIGN_BIT = 23;
    localparam logic [9:0] ZC_TIMEOUT_TICKS = 10'h200;
    localparam logic [9:0] LEVEL_STEP = 10'h001;
    localparam logic [7:0] MUTE_CODE = 8'hFF;
    localparam logic [23:0] SAMPLE_MIN = 24'h800000;
    localparam logic [23:0] SAMPLE_MAX = 24'h7FFFFF;
    localparam logic [23:0] SAMPLE_ZERO = 24'h000000;

    typedef struct packed {
        logic [23:0] a;
        logic [23:0] b;
    } sample_pair_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage : codec_ctl_pkg
`default_nettype wire

// File: rtl/level_ramp.sv
// per-channel level change engine: immediate, crossing wait, ramp, ramp with wait
`timescale 1ns/100ps
`default_nettype none
module level_ramp (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic lr_tick,
    input wire logic zero_cross,
    input wire logic [1:0] mode,
    input wire logic [7:0] target_code,
    output logic [9:0] level
);
    localparam logic [9:0] LEVEL_STEP_1 = codec_ctl_pkg::LEVEL_STEP;
    typedef struct packed {
        logic [9:0] level;
        logic [9:0] timer;
    } ramp_state_t;
    ramp_state_t st_reg;
    ramp_state_t st_next;
    logic [9:0] goal;
    logic pending;
    logic up;
    logic wait_done;
    logic [9:0] stepped;

    always_comb begin
        goal = {target_code, 2'h0};
        pending = st_reg.level != goal;
        up = goal > st_reg.level;
        wait_done = zero_cross || (st_reg.timer >= codec_ctl_pkg::ZC_TIMEOUT_TICKS);
        stepped = up ? st_reg.level + codec_ctl_pkg::LEVEL_STEP
                     : st_reg.level - codec_ctl_pkg::LEVEL_STEP;
        st_next = st_reg;
        if (!pending) begin
            st_next.timer = '0;
        end else if (lr_tick && st_reg.timer < codec_ctl_pkg::ZC_TIMEOUT_TICKS) begin
            st_next.timer = st_reg.timer + 10'h001;
        end
        case (mode)
            codec_ctl_pkg::MODE_IMMEDIATE: begin
                if (pending) st_next.level = goal;
            end
            codec_ctl_pkg::MODE_WAIT: begin
                if (pending && wait_done) begin
                    st_next.level = goal;
                    st_next.timer = '0;
                end
            end
            codec_ctl_pkg::MODE_RAMP: begin
                if (pending && lr_tick) st_next.level = stepped;
            end
            default: begin
                if (pending && wait_done) begin
                    st_next.level = stepped;
                    st_next.timer = '0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) st_reg <= '0;
        else st_reg <= st_next;
    end

    assign level = st_reg.level;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_immediate_apply: assert property (mode == codec_ctl_pkg::MODE_IMMEDIATE && pending
        ##1 $stable(mode) |-> st_reg.level == $past(goal))
        else $error("immediate mode did not apply level");
    a_ramp_one_step: assert property (mode == codec_ctl_pkg::MODE_RAMP ##1 $stable(mode)
        && $changed(st_reg.level) |-> $past(lr_tick)
        && (st_reg.level - $past(st_reg.level) == LEVEL_STEP_1
        || $past(st_reg.level) - st_reg.level == LEVEL_STEP_1))
        else $error("ramp moved more than one eighth step");
    a_wait_cause: assert property (mode == codec_ctl_pkg::MODE_WAIT ##1 $stable(mode)
        && $changed(st_reg.level) |-> $past(zero_cross)
        || $past(st_reg.timer) >= codec_ctl_pkg::ZC_TIMEOUT_TICKS)
        else $error("crossing wait applied change without cause");
    a_timer_bound: assert property (st_reg.timer <= codec_ctl_pkg::ZC_TIMEOUT_TICKS)
        else $error("crossing timeout counter overran");
endmodule : level_ramp
`default_nettype wire

// File: rtl/event_flags.sv
// sticky event flags with synchroniser, mask and edge or level mode per bit
`timescale 1ns/100ps
`default_nettype none
module event_flags (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] cond_raw,
    input wire logic [7:0] mask,
    input wire logic [7:0] mode_hi,
    input wire logic [7:0] mode_lo,
    input wire logic read_clear,
    output logic [7:0] flags
);
    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] prev;
        logic [7:0] flags;
    } flag_state_t;
    flag_state_t st_reg;
    flag_state_t st_next;
    logic [7:0] set_evt;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            logic [1:0] code;
            assign code = {mode_hi[i], mode_lo[i]};
            assign set_evt[i] = (code == codec_ctl_pkg::EVM_RISE) ?
                                    (st_reg.sync2[i] & ~st_reg.prev[i]) :
                                (code == codec_ctl_pkg::EVM_FALL) ?
                                    (~st_reg.sync2[i] & st_reg.prev[i]) :
                                (code == codec_ctl_pkg::EVM_LEVEL) ?
                                    st_reg.sync2[i] : 1'b0;
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = cond_raw;
        st_next.sync2 = st_reg.sync1;
        st_next.prev = st_reg.sync2;
        st_next.flags = (st_reg.flags & ~{8{read_clear}})
                      | (set_evt & mask & codec_ctl_pkg::EVENT_WMASK);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) st_reg <= '0;
        else st_reg <= st_next;
    end

    assign flags = st_reg.flags & mask;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_set_wins: assert property (read_clear && (set_evt & mask & codec_ctl_pkg::EVENT_WMASK)
        != 8'h00 |=> (st_reg.flags & $past(set_evt & mask)) != 8'h00)
        else $error("event lost in clearing cycle");
    a_masked_block: assert property ((set_evt & ~mask) != 8'h00 && read_clear
        |=> (st_reg.flags & $past(set_evt & ~mask)) == 8'h00)
        else $error("masked event updated a flag");
endmodule : event_flags
`default_nettype wire

// File: tb/host_model.sv
// host model: issues register writes and reads on the control port
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic ref_clk,
    input wire logic [7:0] rdata,
    output var codec_ctl_pkg::reg_req_t reg_req
);
    initial reg_req = '0;
    // one request per call, released bus shows inverted address and data
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
        reg_req = '{addr: a, wdata: d, wr: w, rd: ~w};
        @(negedge ref_clk);
        reg_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
        @(negedge ref_clk);
    endtask : put
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        put(a, 8'h00, 1'b0);
        d = rdata;
    endtask : rd
endmodule : host_model
`default_nettype wire

// File: tb/tb.sv
// self-checking testbench for the codec status and transmitter control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    integer fail_count = 0, n_tests = 0, seed = 32'hF538;
    logic [7:0] r, c, rdata, vol_a = 8'h00, vol_b = 8'h00;
    logic [63:0] d;
    logic [9:0] atten_a, atten_b;
    logic [1:0] tx_format_sel;
    codec_ctl_pkg::reg_req_t reg_req;
    codec_ctl_pkg::sample_pair_t dac_in = '0, tx_in = '0, dac_out, tx_sub;
    logic ref_clk = 1'b0, rstn = 1'b0, left_right_clock = 1'b0, dac_mute = 1'b0;
    logic dac_in_valid = 1'b0, tx_in_valid = 1'b0, cs_in_a = 1'b0, cs_in_b = 1'b0;
    logic tx_line_in = 1'b0, copy_slot = 1'b0, clock_fault_raw = 1'b0;
    logic over_range_raw = 1'b0, under_range_raw = 1'b0;
    logic dac_out_valid, tx_sub_valid, tx_cs_a, tx_cs_b, tx_validity, tx_pin;
    logic cbuf_access_width, copy_strobe;
    logic [7:0] ad[8] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h05};
    logic [7:0] rs[8] = '{8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] wm[8] = '{8'hE0, 8'h00, 8'h1B, 8'h1B, 8'h1B, 8'h60, 8'hFF, 8'h00};
    always #10 ref_clk = ~ref_clk;
    codec_status_tx_ctl DUT (.ref_clk, .rstn, .reg_req, .rdata, .left_right_clock, .dac_mute,
        .vol_a, .vol_b, .dac_in, .dac_in_valid, .dac_out, .dac_out_valid, .atten_a, .atten_b,
        .tx_in, .tx_in_valid, .cs_in_a, .cs_in_b, .tx_line_in, .copy_slot, .clock_fault_raw,
        .over_range_raw, .under_range_raw, .tx_sub, .tx_sub_valid, .tx_cs_a, .tx_cs_b,
        .tx_validity, .tx_pin, .tx_format_sel, .cbuf_access_width, .copy_strobe);
    host_model host (.ref_clk, .rdata, .reg_req);
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, r);
        chk(r, e);
    endtask : rchk
    task automatic tick(input int n);
        repeat (n) begin
            left_right_clock = 1'b1;
            cyc(4);
            left_right_clock = 1'b0;
            cyc(4);
        end
    endtask : tick
    task automatic slot(input logic e);
        copy_slot = 1'b1;
        cyc(1);
        copy_slot = 1'b0;
        chk(copy_strobe, e);
    endtask : slot
    function automatic logic [47:0] tx_exp(input logic [7:0] k, input logic [47:0] x);
        logic [23:0] s;
        s = k[0] ? x[23:0] : x[47:24];
        if (k[4]) return '0;
        return k[2] ? {s, s} : x;
    endfunction : tx_exp
    function automatic logic [23:0] neg(input logic [23:0] s);
        return (s == 24'h800000) ? 24'h7FFFFF : -s;
    endfunction : neg
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    initial begin
        #400000;
        fail_count++;
        print_verdict();
    end
    initial begin
        cyc(10);
        rstn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rchk(ad[i], rs[i]);
            host.wr(ad[i], 8'hFF);
            rchk(ad[i], wm[i]);
        end
        $display("register test done");
        for (int k = 0; k < 40; k++) begin
            c = 8'($random(seed));
            d = {$random(seed), $random(seed)};
            if (k == 0) d[47:24] = 24'h800000;
            host.wr(8'h12, c);
            {cs_in_b, cs_in_a, tx_line_in} = d[50:48];
            tx_in = d[47:0];
            dac_in = d[47:0];
            {tx_in_valid, dac_in_valid} = 2'b11;
            cyc(1);
            {tx_in_valid, dac_in_valid} = 2'b00;
            chk({dac_out_valid, tx_sub_valid}, 2'b11);
            chk(tx_sub, tx_exp(c, d[47:0]));
            chk(dac_out, {neg(d[47:24]), neg(d[23:0])});
            chk(tx_pin, d[48] & ~c[5]);
            chk({tx_validity, tx_format_sel}, {c[3], c[7:6]});
            chk({tx_cs_a, tx_cs_b}, c[1] ? {2{d[49+c[0]]}} : {d[49], d[50]});
        end
        $display("data test done");
        host.wr(8'h0E, 8'h1B);
        host.wr(8'h0F, 8'h00);
        host.wr(8'h10, 8'h00);
        clock_fault_raw = 1'b1;
        cyc(8);
        rchk(8'h0D, 8'h08);
        rchk(8'h0D, 8'h00);
        host.wr(8'h10, 8'h08);
        clock_fault_raw = 1'b0;
        cyc(8);
        rchk(8'h0D, 8'h08);
        host.wr(8'h0F, 8'h03);
        over_range_raw = 1'b1;
        cyc(8);
        rchk(8'h0D, 8'h02);
        rchk(8'h0D, 8'h02);
        host.wr(8'h0E, 8'h19);
        under_range_raw = 1'b1;
        cyc(8);
        rchk(8'h0D, 8'h01);
        host.wr(8'h0E, 8'h10);
        chk(cbuf_access_width, 1'b1);
        slot(1'b0);
        cyc(6);
        rchk(8'h0D, 8'h00);
        host.wr(8'h11, 8'h00);
        chk(cbuf_access_width, 1'b0);
        slot(1'b1);
        cyc(6);
        rchk(8'h0D, 8'h10);
        $display("status test done");
        host.wr(8'h0C, 8'h00);
        {vol_a, vol_b} = 16'($random(seed));
        cyc(3);
        chk({atten_a, atten_b}, {vol_a, 2'b00, vol_b, 2'b00});
        {vol_a, vol_b} = 16'h1010;
        cyc(3);
        host.wr(8'h0C, 8'h80);
        {vol_a, vol_b} = 16'h110F;
        tick(2);
        chk({atten_a, atten_b}, {10'h042, 10'h03E});
        tick(3);
        chk({atten_a, atten_b}, {10'h044, 10'h03C});
        host.wr(8'h0C, 8'h40);
        vol_a = 8'h20;
        tick(508);
        chk(atten_a, 10'h044);
        tick(6);
        chk(atten_a, 10'h080);
        host.wr(8'h0C, 8'hC0);
        {vol_a, vol_b} = 16'h1F10;
        repeat (3) begin
            dac_in.a[23] = ~dac_in.a[23];
            dac_in_valid = 1'b1;
            cyc(1);
            dac_in_valid = 1'b0;
            chk(dac_out, dac_in);
            cyc(1);
        end
        chk({atten_a, atten_b}, {10'h07D, 10'h03C});
        host.wr(8'h0C, 8'h00);
        dac_mute = 1'b1;
        cyc(3);
        chk({atten_a, atten_b}, {10'h3FC, 10'h3FC});
        $display("level test done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
